// [verilog/pll_clock_manager.sv]
// Four-loop clock manager with an AHB-Lite register slave
`timescale 1ns/1ns
`include "pll_clock_manager_defines.svh"
module pll_clock_manager (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Device configuration state
   input wire logic config_done,
   // Reference, feedback and serial pins
   input wire logic first_dedicated_clock_pin,
   input wire logic second_dedicated_clock_pin,
   input wire logic [3:0] fb_pin,
   input wire logic [1:0] serial_data,
   // Lock pin as user pin
   input wire logic [3:0] lock_pin_in,
   input wire logic [3:0] user_out,
   input wire logic [3:0] user_oe,
   // Per-loop pins and interrupt
   output pll_clock_manager_pkg::loop_pins_t [3:0] pins,
   output logic irq
);
   import pll_clock_manager_pkg::*;

   logic hreadyout_ff;
   logic [31:0] hrdata_ff;
   logic wr_pend_ff;
   logic [11:0] addr_ff;
   logic [3:0] ctrl_ff;
   logic [`IRQ_W-1:0] mask_ff;
   logic [`IRQ_W-1:0] irq_stat_ff;
   logic irq_ff;
   loop_cfg_t cfg_ff [4];
   loop_div_t div_ff [4];

   logic [3:0] locked_w;
   logic [3:0] err_w;
   logic [3:0] lock_ev;
   logic [3:0] lost_ev;
   logic [3:0] err_ev;
   logic [1:0] ser_ev;
   logic [15:0] per_w [4];
   logic [7:0] word_w [4];

   // Bus decode: address phase for reads, latched address for writes
   wire take = hsel & htrans[1] & hready;
   wire [11:0] ra = haddr[11:0];
   wire r_loop = (ra >= `LOOP_BASE) && (ra < `LOOP_END);
   wire [3:0] r_blk = ra[7:4] - 4'h1;
   wire [1:0] r_idx = r_blk[1:0];
   wire [1:0] r_sub = ra[3:2];
   wire w_loop = (addr_ff >= `LOOP_BASE) && (addr_ff < `LOOP_END);
   wire [3:0] w_blk = addr_ff[7:4] - 4'h1;
   wire [1:0] w_idx = w_blk[1:0];
   wire [1:0] w_sub = addr_ff[3:2];
   wire w_ctrl = wr_pend_ff && (addr_ff == `OFS_CTRL);
   wire w_clr = wr_pend_ff && (addr_ff == `OFS_IRQ_STAT);
   wire w_mask = wr_pend_ff && (addr_ff == `OFS_IRQ_MASK);
   wire w_cfg = wr_pend_ff && w_loop && (w_sub == `SUB_CFG);
   wire w_div = wr_pend_ff && w_loop && (w_sub == `SUB_DIV);

   wire [31:0] loop_rd =
      (r_sub == `SUB_CFG) ? {8'h00, cfg_ff[r_idx]} :
      (r_sub == `SUB_DIV) ? div_ff[r_idx] :
      (r_sub == `SUB_MEAS) ? {8'h00, word_w[r_idx], per_w[r_idx]} :
      32'h00000000;
   wire [31:0] rd_val =
      r_loop ? loop_rd :
      (ra == `OFS_CTRL) ? {28'h0000000, ctrl_ff} :
      (ra == `OFS_STATUS) ? {23'h000000, config_done, err_w, locked_w} :
      (ra == `OFS_IRQ_STAT) ? {18'h00000, irq_stat_ff} :
      (ra == `OFS_IRQ_MASK) ? {18'h00000, mask_ff} :
      32'h00000000;

   // Zero-wait slave, every response OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_ff <= 1'b0;
         wr_pend_ff <= 1'b0;
         addr_ff <= 12'h000;
         hrdata_ff <= 32'h00000000;
      end else begin
         hreadyout_ff <= 1'b1;
         wr_pend_ff <= take & hwrite;
         if (take) addr_ff <= ra;
         if (take & ~hwrite) hrdata_ff <= rd_val;
      end
   end

   // Configuration registers: the loops are set up here alone
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= `CTRL_RST;
         mask_ff <= `MASK_RST;
         for (int i = 0; i < 4; i++) begin
            cfg_ff[i] <= loop_cfg_t'(`CFG_RST);
            div_ff[i] <= loop_div_t'(`DIV_RST);
         end
      end else begin
         if (w_ctrl) ctrl_ff <= hwdata[3:0];
         if (w_mask) mask_ff <= hwdata[`IRQ_W-1:0];
         if (w_cfg) cfg_ff[w_idx] <= loop_cfg_t'(hwdata[23:0]);
         if (w_div) div_ff[w_idx] <= loop_div_t'(hwdata);
      end
   end

   // Sticky events; a new event wins over a write-one clear
   wire [`IRQ_W-1:0] ev_set = {ser_ev, err_ev, lost_ev, lock_ev};
   wire [`IRQ_W-1:0] ev_clr = w_clr ? hwdata[`IRQ_W-1:0] : '0;
   wire [`IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~ev_clr) | ev_set;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq_ff <= |(nxt_irq_stat & mask_ff);
      end
   end

   // Factor pairing between clock 1 (loop 0) and clock 2 (loop 1)
   wire [1:0] fact1 = ctrl_ff[`CTRL_FACT1_LSB+:2];
   wire [1:0] fact2 = ctrl_ff[`CTRL_FACT2_LSB+:2];
   wire pair_ok = (fact1 != 2'b11) && (fact2 != 2'b11) &&
                  (fact1 <= fact2);
   wire both_pin2 = cfg_ff[0].en & cfg_ff[0].src &
                    cfg_ff[1].en & cfg_ff[1].src;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gen_loop
         loop_state_t st_ff;
         loop_state_t nxt_st;
         logic ref_prev_ff;
         logic fb_prev_ff;
         logic [15:0] per_cnt_ff;
         logic [15:0] per_ff;
         logic [10:0] lock_cnt_ff;
         logic fb_seen_ff;
         logic err_ff;
         logic [28:0] acc_ff;
         logic [29:0] hold_ff;
         logic gclk_ff;
         logic clk_pin_ff;
         logic lock_pin_ff;
         logic lock_oe_ff;
         logic user_in_ff;

         loop_cfg_t c;
         loop_div_t d;
         assign c = cfg_ff[g];
         assign d = div_ff[g];

         // First pin barred when both shared loops sit on the second
         wire ref_now = c.src ? second_dedicated_clock_pin
                              : first_dedicated_clock_pin;
         wire pin1_bad = ~c.src & both_pin2;
         wire ref_rise = ref_now & ~ref_prev_ff;
         wire fb_rise = fb_pin[g] & ~fb_prev_ff;
         wire [1:0] fshift = (g == 0) ? fact1 : (g == 1) ? fact2 : 2'b00;
         wire [9:0] m_eff = {2'b00, d.m} << fshift;
         wire [7:0] post = c.sel_v ? {3'b000, d.v} : d.k;
         wire [28:0] modv = 29'(d.n) * 29'(post) * 29'(per_ff);
         wire [10:0] step = {m_eff, 1'b0};
         wire [17:0] dm = 18'(c.delay) * 18'(m_eff);
         wire div_ok = (d.m >= `MK_MIN) && (d.m <= `MK_MAX) &&
                       (d.k >= `MK_MIN) && (d.k <= `MK_MAX) &&
                       (d.n >= `NV_MIN) && (d.n <= `NV_MAX) &&
                       (d.v >= `NV_MIN) && (d.v <= `NV_MAX);
         // Until the period is known the delay bound cannot be judged
         wire dly_ok = (per_ff == 16'h0000) |
                       (29'(dm) <= modv);
         wire mode_ok = (~c.serial | (g < 2)) & ~pin1_bad &
                        ((g >= 2) | pair_ok);
         wire cfg_bad = c.en & config_done & ~(div_ok & mode_ok & dly_ok);
         wire run = config_done & c.en & ~cfg_bad;
         // Period is measured even while the setup is refused, so the
         // delay check never works from a stale zero period
         wire meas_on = config_done & c.en;
         wire lost = per_cnt_ff >= `REF_LOSS_CYC;
         wire acq_done = lock_cnt_ff == 11'(`LOCK_CYC - 1);
         wire fb_ok = ~c.fb_ext | fb_seen_ff | fb_rise;

         always_comb begin
            nxt_st = st_ff;
            unique case (st_ff)
               LOOP_IDLE: if (run) nxt_st = LOOP_ACQ;
               LOOP_ACQ: begin
                  if (!run) nxt_st = LOOP_IDLE;
                  else if (!lost && acq_done && per_ff != 16'h0000 && fb_ok)
                     nxt_st = LOOP_LOCKED;
               end
               LOOP_LOCKED: begin
                  if (!run) nxt_st = LOOP_IDLE;
                  else if (lost) nxt_st = LOOP_ACQ;
               end
               default: nxt_st = LOOP_IDLE;
            endcase
         end

         wire enter = (st_ff != LOOP_LOCKED) && (nxt_st == LOOP_LOCKED);
         wire leave = (st_ff == LOOP_LOCKED) && (nxt_st != LOOP_LOCKED);
         wire locked = st_ff == LOOP_LOCKED;

         // Reference period and lock timing
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               st_ff <= LOOP_IDLE;
               ref_prev_ff <= 1'b0;
               fb_prev_ff <= 1'b0;
               per_cnt_ff <= 16'h0000;
               per_ff <= 16'h0000;
               err_ff <= 1'b0;
            end else begin
               st_ff <= nxt_st;
               ref_prev_ff <= ref_now;
               fb_prev_ff <= fb_pin[g];
               err_ff <= cfg_bad;
               if (!meas_on) per_cnt_ff <= 16'h0000;
               else if (ref_rise) per_cnt_ff <= 16'h0001;
               else if (per_cnt_ff != 16'hFFFF)
                  per_cnt_ff <= per_cnt_ff + 16'h0001;
               if (!meas_on) per_ff <= 16'h0000;
               else if (ref_rise && per_cnt_ff != 16'h0000 && !lost)
                  per_ff <= per_cnt_ff;
            end
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               lock_cnt_ff <= 11'h000;
               fb_seen_ff <= 1'b0;
            end else begin
               if (st_ff != LOOP_ACQ || lost || acq_done)
                  lock_cnt_ff <= 11'h000;
               else
                  lock_cnt_ff <= lock_cnt_ff + 11'h001;
               if (st_ff != LOOP_ACQ || acq_done) fb_seen_ff <= 1'b0;
               else if (fb_rise) fb_seen_ff <= 1'b1;
            end
         end

         // Generated clock: accumulator toggles at 2*fref*m/(n*post), so the clock runs at fref*m/(n*post).
         // Output above hclk/2 cannot be shown; the clock then toggles every cycle, at hclk/2.
         wire [29:0] sum = 30'(acc_ff) + 30'(step);
         wire [29:0] dm2 = {11'h000, dm, 1'b0};
         wire [29:0] hold_init = c.dly_dec ? ({modv, 1'b0} - dm2) : dm2;
         wire wrap = sum >= 30'(modv);
         wire holding = hold_ff >= 30'(step);
         wire toggle = locked & ~holding & wrap;

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               acc_ff <= 29'h00000000;
               hold_ff <= 30'h00000000;
               gclk_ff <= 1'b0;
            end else if (enter) begin
               acc_ff <= c.phase[0] ? (modv >> 1) : 29'h00000000;
               gclk_ff <= c.phase[1];
               hold_ff <= hold_init;
            end else if (!locked) begin
               acc_ff <= 29'h00000000;
               hold_ff <= 30'h00000000;
               gclk_ff <= 1'b0;
            end else if (holding) begin
               hold_ff <= hold_ff - 30'(step);
            end else begin
               acc_ff <= wrap ? 29'(sum - 30'(modv)) : sum[28:0];
               if (wrap) gclk_ff <= ~gclk_ff;
            end
         end

         // Pins: clock out, lock indicator or plain user pin
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               clk_pin_ff <= 1'b0;
               lock_pin_ff <= 1'b0;
               lock_oe_ff <= 1'b0;
               user_in_ff <= 1'b0;
            end else begin
               clk_pin_ff <= c.out_en & gclk_ff;
               lock_pin_ff <= c.lock_pin_en ? locked : user_out[g];
               lock_oe_ff <= c.lock_pin_en | user_oe[g];
               user_in_ff <= ~c.lock_pin_en & lock_pin_in[g];
            end
         end

         assign pins[g] = '{gen_clk: gclk_ff, clk_pin: clk_pin_ff,
                            clk_pin_oe: c.out_en, lock_pin: lock_pin_ff,
                            lock_pin_oe: lock_oe_ff, user_in: user_in_ff};
         assign locked_w[g] = locked;
         assign err_w[g] = err_ff;
         assign lock_ev[g] = enter;
         assign lost_ev[g] = leave;
         assign err_ev[g] = cfg_bad & ~err_ff;
         assign per_w[g] = per_ff;

         // Serial capture on each rising edge of the multiplied clock
         if (g < 2) begin : gen_ser
            logic [6:0] sh_ff;
            logic [2:0] bit_ff;
            logic [7:0] word_ff;
            wire cap = toggle & ~gclk_ff & c.serial;
            wire full = cap && (bit_ff == 3'h7);
            always_ff @(posedge hclk or negedge hresetn) begin
               if (!hresetn) begin
                  sh_ff <= 7'h00;
                  bit_ff <= 3'h0;
                  word_ff <= 8'h00;
               end else if (!locked) begin
                  bit_ff <= 3'h0;
               end else if (cap) begin
                  sh_ff <= {sh_ff[5:0], serial_data[g]};
                  bit_ff <= bit_ff + 3'h1;
                  if (full) word_ff <= {sh_ff, serial_data[g]};
               end
            end
            assign word_w[g] = word_ff;
            assign ser_ev[g] = full;
         end else begin : gen_noser
            assign word_w[g] = 8'h00;
         end
      end
   endgenerate

   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = 1'b0;
   assign irq = irq_ff;

endmodule : pll_clock_manager

// [verilog/pll_clock_manager_defines.svh]
// Register offsets, field positions, reset values and timing counts
// What this block does
// - With both loops 0 and 1 on the second pin, the first pin is unusable.
// - Factor pairs: x1/x1; x1 or x2 with x2; x1, x2 or x4 with x4.
// - Output is input times m/(n*k) or m/(n*v); m,k 2..160; n,v 1..16.
// - Generated clock phase selectable in quarter-period (90 degree) steps.
// - Generated clock delay raised or lowered by up to one output period.
// - Each loop has its own lock indicator, high once locked to reference.
// - A lock indicator is optional; when off its pin is a plain user pin.
// - Four independent loops; loops 0 and 1 also serve serial capture.
// - Generated clock may drive an output pin; feedback may route via a pin.
// - Serial loops multiply the forwarded clock to sample faster data bits.
// - Loops are set up by configuration registers alone, no outside parts.
// - A loop ignores its reference until configuration is done.
// - A valid reference is locked once ten microseconds of acquisition have passed.
`ifndef PLL_CLOCK_MANAGER_DEFINES_SVH
`define PLL_CLOCK_MANAGER_DEFINES_SVH

`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_IRQ_STAT 12'h008
`define OFS_IRQ_MASK 12'h00C
`define LOOP_BASE 12'h010
`define LOOP_END 12'h050
`define SUB_CFG 2'h0
`define SUB_DIV 2'h1
`define SUB_MEAS 2'h2

`define CTRL_FACT1_LSB 0
`define CTRL_FACT2_LSB 2
`define IRQ_LOCK_LSB 0
`define IRQ_LOST_LSB 4
`define IRQ_ERR_LSB 8
`define IRQ_SER_LSB 12
`define IRQ_W 14

`define CTRL_RST 4'h0
`define CFG_RST 24'h000000
`define DIV_RST 32'h01010202
`define MASK_RST 14'h0000

`define MK_MIN 8'h02
`define MK_MAX 8'hA0
`define NV_MIN 5'h01
`define NV_MAX 5'h10

`define CLK_PERIOD_NS 8
`define T_LOCK_NS 10000
`define LOCK_CYC (`T_LOCK_NS / `CLK_PERIOD_NS)
`define REF_LOSS_CYC 16'h0040

`endif

// [verilog/pll_clock_manager_pkg.sv]
// Types shared by the clock manager
package pll_clock_manager_pkg;

   typedef enum logic [1:0] {
      FACT_X1 = 2'b00,
      FACT_X2 = 2'b01,
      FACT_X4 = 2'b10
   } fact_t;

   typedef enum logic [1:0] {
      LOOP_IDLE = 2'b00,
      LOOP_ACQ = 2'b01,
      LOOP_LOCKED = 2'b10
   } loop_state_t;

   typedef struct packed {
      logic [7:0] delay;
      logic [5:0] rsv;
      logic dly_dec;
      logic sel_v;
      logic [1:0] phase;
      logic serial;
      logic fb_ext;
      logic out_en;
      logic lock_pin_en;
      logic src;
      logic en;
   } loop_cfg_t;

   typedef struct packed {
      logic [2:0] rsv3;
      logic [4:0] v;
      logic [2:0] rsv2;
      logic [4:0] n;
      logic [7:0] k;
      logic [7:0] m;
   } loop_div_t;

   typedef struct packed {
      logic gen_clk;
      logic clk_pin;
      logic clk_pin_oe;
      logic lock_pin;
      logic lock_pin_oe;
      logic user_in;
   } loop_pins_t;

endpackage : pll_clock_manager_pkg

// [dv/pll_clock_manager_assertions.sv]
// Port-level checks for the clock manager
`timescale 1ns/1ns
module pll_clock_manager_checker (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Configuration and pins
   input wire logic config_done,
   input wire logic first_dedicated_clock_pin,
   input wire logic second_dedicated_clock_pin,
   input wire logic [3:0] fb_pin,
   input wire logic [1:0] serial_data,
   input wire logic [3:0] lock_pin_in,
   input wire logic [3:0] user_out,
   input wire logic [3:0] user_oe,
   input wire pll_clock_manager_pkg::loop_pins_t [3:0] pins,
   input wire logic irq
);
   import pll_clock_manager_pkg::*;
   logic [10:0] run_cnt_ff;
   logic [7:0] quiet_cnt_ff;
   logic ref_q_ff;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Loop 0 watches the first pin; user drive of its lock pin stays low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_cnt_ff <= 11'h000;
         quiet_cnt_ff <= 8'h00;
         ref_q_ff <= 1'b0;
      end else begin
         ref_q_ff <= first_dedicated_clock_pin;
         if (!config_done) run_cnt_ff <= 11'h000;
         else if (run_cnt_ff != 11'h7FF) run_cnt_ff <= run_cnt_ff + 11'h001;
         if (first_dedicated_clock_pin && !ref_q_ff) quiet_cnt_ff <= 8'h00;
         else if (quiet_cnt_ff != 8'hFF) quiet_cnt_ff <= quiet_cnt_ff + 8'h01;
      end
   end
   sequence unconfigured_s;
      !config_done [*4];
   endsequence
   sequence ref_lost_s;
      quiet_cnt_ff > 8'h48;
   endsequence
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_zero_wait: assert property ($past(hresetn) |-> hreadyout)
      else $error("slave inserted a wait state");
   for (genvar i = 0; i < 4; i++) begin : g_out
      a_clk_pin_gated: assert property (
         pins[i].clk_pin == $past(pins[i].gen_clk && pins[i].clk_pin_oe))
         else $error("clock pin does not follow gated clock");
   end
   a_lock_unconfig: assert property (
      unconfigured_s |-> !pins[0].lock_pin)
      else $error("lock high while unconfigured");
   a_no_early_lock: assert property (
      run_cnt_ff inside {[11'h008:11'h4E1]} |-> !pins[0].lock_pin)
      else $error("lock before acquire time");
   a_lock_lost: assert property (ref_lost_s |-> !pins[0].lock_pin)
      else $error("lock held without reference");
   a_lock_needs_ref: assert property (
      $rose(pins[0].lock_pin) |-> quiet_cnt_ff < 8'h40)
      else $error("lock without recent reference edge");
   a_gen_after_lock: assert property ($rose(pins[0].gen_clk) |->
      pins[0].lock_pin || $past(pins[0].lock_pin))
      else $error("generated clock runs unlocked");
endmodule : pll_clock_manager_checker

bind pll_clock_manager pll_clock_manager_checker u_checker (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .config_done(config_done),
   .first_dedicated_clock_pin(first_dedicated_clock_pin),
   .second_dedicated_clock_pin(second_dedicated_clock_pin),
   .fb_pin(fb_pin), .serial_data(serial_data),
   .lock_pin_in(lock_pin_in), .user_out(user_out), .user_oe(user_oe),
   .pins(pins), .irq(irq));

// [dv/board_clock_source.sv]
// Board reference oscillator with feedback traces and a serial sender
`timescale 1ns/1ns
module board_clock_source #(
   parameter int HALF = 4
) (
   // Clock and control
   input wire logic hclk,
   input wire logic run,
   // Device outputs
   input wire pll_clock_manager_pkg::loop_pins_t [3:0] pins,
   // Board lines
   output logic ref_clk,
   output logic [3:0] fb_pin,
   output logic [1:0] serial_data
);
   import pll_clock_manager_pkg::*;
   logic [7:0] cnt_ff = 8'h00;
   logic [7:0] pat_ff = 8'hA5;
   logic gen_q_ff = 1'b0;
   initial begin
      ref_clk = 1'b0;
      fb_pin = 4'h0;
      serial_data = 2'h0;
   end
   // A stopped oscillator holds its level rather than idling high
   always @(posedge hclk) begin
      gen_q_ff <= pins[0].gen_clk;
      for (int i = 0; i < 4; i++) begin
         fb_pin[i] <= pins[i].clk_pin_oe ? pins[i].clk_pin : ~fb_pin[i];
      end
      if (run) begin
         cnt_ff <= (cnt_ff == 8'(HALF - 1)) ? 8'h00 : cnt_ff + 8'h01;
         if (cnt_ff == 8'(HALF - 1)) ref_clk <= ~ref_clk;
      end
      // Change data on the falling edge so the rising edge sees it settled
      if (gen_q_ff && !pins[0].gen_clk) begin
         serial_data <= {pat_ff[7], pat_ff[7]};
         pat_ff <= {pat_ff[6:0], pat_ff[7]};
      end
   end
endmodule : board_clock_source

// [dv/pll_clock_manager_bench.sv]
// Register-level bench for the clock manager
`timescale 1ns/1ns
module pll_clock_manager_bench;
   import pll_clock_manager_pkg::*;
   localparam logic [11:0] RA [8] = '{12'h000, 12'h004, 12'h008, 12'h00C,
      12'h010, 12'h034, 12'h01C, 12'h050};
   localparam logic [31:0] RV [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
      32'h01010202, 32'h0, 32'h0};
   localparam logic [31:0] DV [12] = '{32'h01010202, 32'h010102A0,
      32'h010102A1, 32'h01010201, 32'h0101A002, 32'h0101A102, 32'h01000202,
      32'h01100202, 32'h01110202, 32'h10010202, 32'h11010202, 32'h00010202};
   localparam logic [11:0] DE = 12'hD6C;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic config_done = 1'b0;
   logic ref_run = 1'b1;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0] lock_pin_in = 4'h0;
   logic [3:0] user_out = 4'hA;
   logic [3:0] user_oe = 4'hA;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, irq, ref_clk;
   logic [1:0] serial_data;
   logic [3:0] fb_pin;
   loop_pins_t [3:0] pins;
   int n_mismatch = 0;
   int comparisons = 0;
   int tick = 0;
   int n;

   pll_clock_manager DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .config_done(config_done),
      .first_dedicated_clock_pin(ref_clk),
      .second_dedicated_clock_pin(ref_clk), .fb_pin(fb_pin),
      .serial_data(serial_data), .lock_pin_in(lock_pin_in),
      .user_out(user_out), .user_oe(user_oe), .pins(pins), .irq(irq));
   board_clock_source #(.HALF(4)) u_src (.hclk(hclk), .run(ref_run),
      .pins(pins), .ref_clk(ref_clk), .fb_pin(fb_pin),
      .serial_data(serial_data));

   initial begin
      forever #4 hclk = ~hclk;
   end

   task close_out;
      if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   // Called just after an edge; waits on hready, never a fixed latency
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h00000, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus

   task wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task rchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rchk

   task cyc(input int k);
      repeat (k) @(posedge hclk);
   endtask : cyc

   task wait_lock;
      n = 0;
      while (pins[0].lock_pin !== 1'b1 && n < 3000) begin
         @(posedge hclk);
         n++;
      end
   endtask : wait_lock

   // Second pass counts one full rise-to-rise period
   task gen_period;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         while (pins[0].gen_clk !== 1'b0 && n < 99) begin
            @(posedge hclk);
            n++;
         end
         while (pins[0].gen_clk !== 1'b1 && n < 99) begin
            @(posedge hclk);
            n++;
         end
      end
   endtask : gen_period

   function automatic logic is_rot(input logic [7:0] w);
      logic [7:0] p;
      p = 8'hA5;
      is_rot = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (w === p) is_rot = 1'b1;
         p = {p[6:0], p[7]};
      end
   endfunction : is_rot

   always @(posedge hclk) begin
      tick <= tick + 1;
      if (tick == 30000) begin
         n_mismatch++;
         close_out();
      end
   end

   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      cyc(2);
      wr(12'h050, 32'hFFFFFFFF);
      wr(12'h004, 32'hFFFFFFFF);
      foreach (RA[i]) rchk(RA[i], RV[i]);
      wr(12'h010, 32'h0000000D);
      wr(12'h00C, 32'h00000001);
      cyc(1500);
      check(32'(pins[0].lock_pin), 32'h0);
      rchk(12'h004, 32'h0);
      config_done <= 1'b1;
      wait_lock();
      check(32'(n >= 32'h4E2 && n <= 32'h4E8), 32'h1);
      cyc(2);
      check(32'(irq), 32'h1);
      rchk(12'h004, 32'h101);
      bus(1'b0, 12'h018, 32'h0);
      check(rd & 32'hFFFF, 32'h8);
      wr(12'h00C, 32'h0);
      cyc(2);
      check(32'(irq), 32'h0);
      rchk(12'h008, 32'h1);
      wr(12'h008, 32'h1);
      rchk(12'h008, 32'h0);
      gen_period();
      check(32'(n), 32'h8);
      wr(12'h000, 32'h5);
      cyc(1300);
      wait_lock();
      gen_period();
      check(32'(n), 32'h4);
      wr(12'h000, 32'h0);
      wr(12'h014, 32'h04010204);
      wr(12'h010, 32'h0000014C);
      wr(12'h010, 32'h0000014D);
      cyc(2);
      wait_lock();
      n = 0;
      while (pins[0].gen_clk !== 1'b1 && n < 9) begin
         @(posedge hclk);
         n++;
      end
      check(32'(n), 32'h1);
      gen_period();
      check(32'(n), 32'h8);
      wr(12'h008, 32'h3FFF);
      ref_run <= 1'b0;
      cyc(100);
      check(32'(pins[0].lock_pin), 32'h0);
      rchk(12'h008, 32'h10);
      ref_run <= 1'b1;
      wr(12'h020, 32'h1);
      for (int f1 = 0; f1 < 3; f1++) begin
         for (int f2 = 0; f2 < 3; f2++) begin
            wr(12'h000, {28'h0, 2'(f2), 2'(f1)});
            cyc(4);
            bus(1'b0, 12'h004, 32'h0);
            check(32'(rd[5:4] != 2'h0), 32'(f1 > f2));
         end
      end
      wr(12'h000, 32'h0);
      wr(12'h040, 32'h1);
      foreach (DV[i]) begin
         wr(12'h044, DV[i]);
         cyc(4);
         bus(1'b0, 12'h004, 32'h0);
         check(32'(rd[7]), 32'(DE[i]));
      end
      wr(12'h044, 32'h01010202);
      for (int d = 9; d > 7; d--) begin
         wr(12'h040, {8'h00, 8'(d), 16'h0001});
         cyc(4);
         bus(1'b0, 12'h004, 32'h0);
         check(32'(rd[7]), 32'(d == 9));
      end
      wr(12'h040, 32'h21);
      wr(12'h020, 32'h21);
      cyc(4);
      bus(1'b0, 12'h004, 32'h0);
      check(32'(rd[7:4]), 32'h8);
      wr(12'h040, 32'h1);
      wr(12'h020, 32'h3);
      wr(12'h010, 32'h0000010F);
      wr(12'h030, 32'h1);
      cyc(4);
      bus(1'b0, 12'h004, 32'h0);
      check(32'(rd[7:4]), 32'hC);
      wr(12'h020, 32'h1);
      cyc(4);
      bus(1'b0, 12'h004, 32'h0);
      check(32'(rd[7:4]), 32'h0);
      lock_pin_in <= 4'h3;
      cyc(3);
      check(32'(pins[1].user_in), 32'h1);
      check(32'(pins[0].user_in), 32'h0);
      check(32'(pins[1].lock_pin), 32'h1);
      check(32'(pins[1].lock_pin_oe), 32'h1);
      wr(12'h010, 32'h0000012D);
      cyc(1300);
      wait_lock();
      cyc(200);
      bus(1'b0, 12'h018, 32'h0);
      check(32'(is_rot(rd[23:16])), 32'h1);
      bus(1'b0, 12'h008, 32'h0);
      check(32'(rd[12]), 32'h1);
      close_out();
   end
endmodule : pll_clock_manager_bench
